// >>> rtl/srw_top.sv
// Supervisor: reset generation, early warning, watchdog and select gating
module srw_top #(
    parameter int unsigned HOLDOFF_CYCLES = srw_pkg::HOLDOFF_CYC,
    parameter int unsigned WDOG_DEF_CYCLES = srw_pkg::WDOG_DEF_CYC,
    parameter int unsigned PULSE_CYCLES = srw_pkg::PULSE_CYC,
    parameter int unsigned SEL_HOLD_CYCLES = srw_pkg::SEL_HOLD_CYC,
    parameter int unsigned CNT_W = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Comparator results and pins, asynchronous
    input wire srw_pkg::srw_cmp_s cmp_in,
    input wire logic kick_in,
    input wire logic select_in_n,
    // Watchdog timing choice, static straps
    input wire srw_pkg::srw_wdcfg_s wd_cfg,
    // Reset and warning outputs
    output logic reset_out_n,
    output logic reset_out,
    output logic early_warning_n,
    output logic overvolt_flag_n,
    // Watchdog outputs
    output logic expiry_flag_n,
    output logic expiry_pulse_n,
    // Gated select
    output logic select_out_n
);

    localparam int unsigned NSYNC = $bits(srw_pkg::srw_cmp_s) + 2;

    srw_pkg::srw_cmp_s cmp_s;
    logic kick_s;
    logic sel_in_n_s;

    // Comparators, kick and select all cross into the clock domain
    srw_sync #(.WIDTH(NSYNC)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({cmp_in, kick_in, select_in_n}),
        .sync_out({cmp_s, kick_s, sel_in_n_s})
    );

    // Threshold condition
    logic trip;
    logic warn;
    always_comb begin
        trip = cmp_s.mode_ext ? cmp_s.ext_reset_low : cmp_s.supply_low;
        trip = trip | cmp_s.manual_low;
        warn = cmp_s.mode_ext ? cmp_s.warn_sense_low : cmp_s.warn_supply;
    end

    // Reset hold-off counter; reset asserted from power-up
    logic [CNT_W-1:0] hold_q;
    logic [CNT_W-1:0] hold_d;
    logic rst_act_q;
    logic rst_act_d;
    always_comb begin
        hold_d = hold_q;
        rst_act_d = rst_act_q;
        if (trip) begin
            hold_d = '0;
            rst_act_d = 1'b1;
        end else if (rst_act_q) begin
            if (hold_q >= CNT_W'(HOLDOFF_CYCLES - 1)) begin
                rst_act_d = 1'b0;
                hold_d = '0;
            end else begin
                hold_d = hold_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_q <= '0;
            rst_act_q <= 1'b1;
        end else begin
            hold_q <= hold_d;
            rst_act_q <= rst_act_d;
        end
    end

    // Watchdog period; capacitor math done once per cycle from straps
    logic [CNT_W-1:0] wd_period;
    logic [CNT_W-1:0] k_tenths;
    always_comb begin
        k_tenths = wd_cfg.supply_5v ? CNT_W'(srw_pkg::WDOG_K5V_TENTHS)
                                    : CNT_W'(srw_pkg::WDOG_K3V_TENTHS);
        if (wd_cfg.use_cap) begin
            wd_period = CNT_W'(k_tenths * CNT_W'(wd_cfg.cap_nf)
                        * CNT_W'(srw_pkg::CYC_PER_TENTH_MS));
        end else begin
            wd_period = CNT_W'(WDOG_DEF_CYCLES);
        end
        if (wd_period == '0) begin
            wd_period = CNT_W'(1);
        end
    end

    // Watchdog: counter, flag, pulse and its lead
    logic kick_prev_q;
    logic kick_prev_d;
    logic [CNT_W-1:0] wd_cnt_q;
    logic [CNT_W-1:0] wd_cnt_d;
    logic expired_q;
    logic expired_d;
    logic flag_n_q;
    logic flag_n_d;
    logic [CNT_W-1:0] pulse_cnt_q;
    logic [CNT_W-1:0] pulse_cnt_d;
    logic pulse_n_q;
    logic pulse_n_d;
    logic [CNT_W-1:0] lead_cnt_q;
    logic [CNT_W-1:0] lead_cnt_d;
    logic kick_edge;

    always_comb begin
        kick_edge = kick_s ^ kick_prev_q;
        kick_prev_d = kick_s;
        wd_cnt_d = wd_cnt_q;
        expired_d = expired_q;
        flag_n_d = flag_n_q;
        pulse_cnt_d = pulse_cnt_q;
        pulse_n_d = pulse_n_q;
        lead_cnt_d = lead_cnt_q;
        if (rst_act_q) begin
            // Counters cleared, outputs forced high
            wd_cnt_d = '0;
            expired_d = 1'b0;
            flag_n_d = 1'b1;
            pulse_cnt_d = '0;
            pulse_n_d = 1'b1;
            lead_cnt_d = '0;
        end else begin
            if (kick_edge) begin
                wd_cnt_d = '0;
                expired_d = 1'b0;
                flag_n_d = 1'b1;
                lead_cnt_d = '0;
            end else if (!expired_q) begin
                if (wd_cnt_q >= wd_period - CNT_W'(1)) begin
                    // Pulse starts now; flag follows after the lead
                    expired_d = 1'b1;
                    wd_cnt_d = '0;
                    pulse_n_d = 1'b0;
                    pulse_cnt_d = '0;
                    lead_cnt_d = CNT_W'(1);
                end else begin
                    wd_cnt_d = wd_cnt_q + CNT_W'(1);
                end
            end
            // Flag trails pulse by the lead time
            if (!kick_edge && lead_cnt_q != '0) begin
                if (lead_cnt_q >= CNT_W'(srw_pkg::LEAD_CYC)) begin
                    flag_n_d = 1'b0;
                    lead_cnt_d = '0;
                end else begin
                    lead_cnt_d = lead_cnt_q + CNT_W'(1);
                end
            end
            // Pulse runs full width even if kick resumes
            if (!pulse_n_q) begin
                if (pulse_cnt_q >= CNT_W'(PULSE_CYCLES - 1)) begin
                    pulse_n_d = 1'b1;
                    pulse_cnt_d = '0;
                end else begin
                    pulse_cnt_d = pulse_cnt_q + CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            kick_prev_q <= 1'b0;
            wd_cnt_q <= '0;
            expired_q <= 1'b0;
            flag_n_q <= 1'b1;
            pulse_cnt_q <= '0;
            pulse_n_q <= 1'b1;
            lead_cnt_q <= '0;
        end else begin
            kick_prev_q <= kick_prev_d;
            wd_cnt_q <= wd_cnt_d;
            expired_q <= expired_d;
            flag_n_q <= flag_n_d;
            pulse_cnt_q <= pulse_cnt_d;
            pulse_n_q <= pulse_n_d;
            lead_cnt_q <= lead_cnt_d;
        end
    end

    // Select gate with short grace window into reset
    logic rst_prev_q;
    logic rst_prev_d;
    logic grace_q;
    logic grace_d;
    logic [CNT_W-1:0] grace_cnt_q;
    logic [CNT_W-1:0] grace_cnt_d;
    logic sel_n_q;
    logic sel_n_d;

    always_comb begin
        rst_prev_d = rst_act_q;
        grace_d = grace_q;
        grace_cnt_d = grace_cnt_q;
        if (rst_act_q && !rst_prev_q && !sel_in_n_s) begin
            // Lets an in-flight memory cycle finish
            grace_d = 1'b1;
            grace_cnt_d = '0;
        end else if (grace_q) begin
            if (sel_in_n_s || grace_cnt_q >= CNT_W'(SEL_HOLD_CYCLES - 1)) begin
                grace_d = 1'b0;
                grace_cnt_d = '0;
            end else begin
                grace_cnt_d = grace_cnt_q + CNT_W'(1);
            end
        end
        if (!rst_act_q) begin
            grace_d = 1'b0;
            grace_cnt_d = '0;
        end
        sel_n_d = !(!sel_in_n_s && (!rst_act_q || grace_d));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rst_prev_q <= 1'b1;
            grace_q <= 1'b0;
            grace_cnt_q <= '0;
            sel_n_q <= 1'b1;
        end else begin
            rst_prev_q <= rst_prev_d;
            grace_q <= grace_d;
            grace_cnt_q <= grace_cnt_d;
            sel_n_q <= sel_n_d;
        end
    end

    // Output flops
    logic rst_n_q;
    logic rst_hi_q;
    logic warn_n_q;
    logic ov_n_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rst_n_q <= 1'b0;
            rst_hi_q <= 1'b1;
            warn_n_q <= 1'b1;
            ov_n_q <= 1'b1;
        end else begin
            rst_n_q <= !rst_act_d;
            rst_hi_q <= rst_act_d;
            warn_n_q <= !warn;
            ov_n_q <= !cmp_s.overvolt;
        end
    end

    assign reset_out_n = rst_n_q;
    assign reset_out = rst_hi_q;
    assign early_warning_n = warn_n_q;
    assign overvolt_flag_n = ov_n_q;
    assign expiry_flag_n = flag_n_q;
    assign expiry_pulse_n = pulse_n_q;
    assign select_out_n = sel_n_q;

endmodule

// >>> rtl/srw_pkg.sv
// Package: constants and carriers for the supervisor reset and watchdog block
package srw_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ = 10_000_000;

    // Reset hold-off after threshold clears, in ms
    localparam int unsigned HOLDOFF_MS = 200;
    localparam int unsigned HOLDOFF_CYC = HOLDOFF_MS * (CLK_HZ / 1000);

    // Default watchdog timeout, in ms (1.6 s)
    localparam int unsigned WDOG_DEF_MS = 1600;
    localparam int unsigned WDOG_DEF_CYC = WDOG_DEF_MS * (CLK_HZ / 1000);

    // Capacitor scale factors, in tenths of ms per nF
    localparam int unsigned WDOG_K5V_TENTHS = 270;
    localparam int unsigned WDOG_K3V_TENTHS = 162;
    // Cycles per tenth of a ms
    localparam int unsigned CYC_PER_TENTH_MS = CLK_HZ / 10_000;

    // Expiry pulse least width, in us
    localparam int unsigned PULSE_US = 500;
    // Scaled in two steps so the product stays inside 32 bits
    localparam int unsigned PULSE_CYC = (PULSE_US * (CLK_HZ / 1000) + 999) / 1000;

    // Lead of pulse over flag, in ns (70 ns rounds up to one cycle)
    localparam int unsigned LEAD_NS = 70;
    localparam int unsigned LEAD_CYC_RAW = (LEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned LEAD_CYC = (LEAD_CYC_RAW < 1) ? 1 : LEAD_CYC_RAW;

    // Longest select pass-through after reset asserts, in us
    localparam int unsigned SEL_HOLD_US = 15;
    localparam int unsigned SEL_HOLD_CYC_RAW = (SEL_HOLD_US * CLK_HZ) / 1_000_000;
    localparam int unsigned SEL_HOLD_CYC = (SEL_HOLD_CYC_RAW < 1) ? 1 : SEL_HOLD_CYC_RAW;

    // Comparator results after synchronising, all active high
    typedef struct packed {
        logic supply_low;
        logic ext_reset_low;
        logic mode_ext;
        logic warn_supply;
        logic warn_sense_low;
        logic overvolt;
        logic manual_low;
    } srw_cmp_s;

    // Watchdog timing choice
    typedef struct packed {
        logic use_cap;
        logic supply_5v;
        logic [15:0] cap_nf;
    } srw_wdcfg_s;

endpackage

// >>> rtl/srw_sync.sv
// Two-flip-flop synchroniser, one per bit
module srw_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// >>> tb/srw_top_sva.sv
// Checker on the supervisor block ports
module srw_chk #(
    parameter int unsigned HOLDOFF_CYCLES = 50,
    parameter int unsigned PULSE_CYCLES = 10,
    parameter int unsigned SEL_HOLD_CYCLES = 8
) (
    // Clock, reset
    input wire logic clk_sys,
    input wire logic rst,
    // Inputs
    input wire srw_pkg::srw_cmp_s cmp_in,
    input wire logic kick_in,
    // Outputs
    input wire logic reset_out_n,
    input wire logic reset_out,
    input wire logic early_warning_n,
    input wire logic overvolt_flag_n,
    input wire logic expiry_flag_n,
    input wire logic expiry_pulse_n,
    input wire logic select_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic trip;
    logic kick_q;
    logic [31:0] clr_q, pl_q, rl_q, ka_q;
    assign trip = (cmp_in.mode_ext ? cmp_in.ext_reset_low : cmp_in.supply_low)
        | cmp_in.manual_low;
    // Counters cover spans too long for repetition
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clr_q <= 32'h0;
            pl_q <= 32'h0;
            rl_q <= 32'h0;
            ka_q <= 32'h0;
            kick_q <= 1'h0;
        end else begin
            clr_q <= trip ? 32'h0 : clr_q + 32'h1;
            pl_q <= expiry_pulse_n ? 32'h0 : pl_q + 32'h1;
            rl_q <= reset_out_n ? 32'h0 : rl_q + 32'h1;
            ka_q <= (kick_in != kick_q) ? 32'h0 : ka_q + 32'h1;
            kick_q <= kick_in;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_inv; reset_out == !reset_out_n; endproperty
    a_inv: assert property (p_inv) else $error("outputs not inverse");
    property p_trip; trip [*4] |=> !reset_out_n; endproperty
    a_trip: assert property (p_trip) else $error("trip ignored");
    property p_hold; $rose(reset_out_n) |-> clr_q >= HOLDOFF_CYCLES
        && clr_q <= HOLDOFF_CYCLES + 6; endproperty
    a_hold: assert property (p_hold) else $error("hold-off length");
    property p_ovf; $stable(cmp_in.overvolt) [*4]
        |=> overvolt_flag_n != $past(cmp_in.overvolt); endproperty
    a_ovf: assert property (p_ovf) else $error("overvolt flag");
    property p_ewn; (cmp_in.mode_ext ? cmp_in.warn_sense_low : cmp_in.warn_supply) [*4]
        |=> !early_warning_n; endproperty
    a_ewn: assert property (p_ewn) else $error("warning missing");
    property p_lead; $fell(expiry_pulse_n) |=> $fell(expiry_flag_n); endproperty
    a_lead: assert property (p_lead) else $error("pulse lead");
    property p_pw; $rose(expiry_pulse_n) |-> pl_q >= PULSE_CYCLES; endproperty
    a_pw: assert property (p_pw) else $error("pulse short");
    // Reset also forces the flag high, so a rise in reset is legal
    property p_flg; $rose(expiry_flag_n) |-> ka_q <= 32'h6 || !reset_out_n; endproperty
    a_flg: assert property (p_flg) else $error("flag rose without kick");
    property p_grc; rl_q > SEL_HOLD_CYCLES + 3 |-> select_out_n; endproperty
    a_grc: assert property (p_grc) else $error("select passed in reset");
    property p_wdr; !reset_out_n [*2] |-> expiry_flag_n && expiry_pulse_n; endproperty
    a_wdr: assert property (p_wdr) else $error("expiry in reset");
endmodule
bind srw_top srw_chk #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
    .SEL_HOLD_CYCLES(SEL_HOLD_CYCLES)) chk_u (.clk_sys(clk_sys), .rst(rst),
    .cmp_in(cmp_in), .kick_in(kick_in), .reset_out_n(reset_out_n), .reset_out(reset_out),
    .early_warning_n(early_warning_n), .overvolt_flag_n(overvolt_flag_n),
    .expiry_flag_n(expiry_flag_n), .expiry_pulse_n(expiry_pulse_n),
    .select_out_n(select_out_n));

// >>> tb/srw_cpu.sv
// Processor-side model: watchdog kicks and memory select
module srw_cpu #(
    parameter int KICK_GAP = 20
) (
    // Clock
    input wire logic clk_sys,
    // Bench control
    input wire logic kick_en,
    input wire logic kick_one,
    input wire logic sel_req,
    // Pins to supervisor
    output logic kick_in,
    output logic select_in_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 0;
    logic kick_q = 1'h0;
    // Either edge kicks, so a toggle serves
    always @(posedge clk_sys) begin
        gap <= (kick_en && gap < KICK_GAP) ? gap + 1 : 0;
        if (kick_one || (kick_en && gap == KICK_GAP)) begin
            kick_q <= !kick_q;
        end
    end
    assign kick_in = kick_q;
    assign select_in_n = !sel_req;
endmodule

// >>> tb/tb.sv
// Self-checking bench for the supervisor block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Shortened counts keep the run brief
    localparam int HO = 50;
    localparam int WD = 100;
    localparam int PW = 10;
    localparam int SH = 8;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    srw_pkg::srw_cmp_s cmp_in = 7'h00;
    srw_pkg::srw_wdcfg_s wd_cfg = 18'h10000;
    logic kick_en = 1'h1;
    logic kick_one = 1'h0;
    logic sel_req = 1'h0;
    logic kick_in, select_in_n;
    wire [6:0] o;
    int errors = 0;
    int tests_run = 0;
    int k;
    srw_top #(.HOLDOFF_CYCLES(HO), .WDOG_DEF_CYCLES(WD), .PULSE_CYCLES(PW),
        .SEL_HOLD_CYCLES(SH)) dut_u (.clk_sys(clk_sys), .rst(rst), .cmp_in(cmp_in),
        .kick_in(kick_in), .select_in_n(select_in_n), .wd_cfg(wd_cfg),
        .reset_out_n(o[6]), .reset_out(o[5]), .early_warning_n(o[4]),
        .overvolt_flag_n(o[3]), .expiry_flag_n(o[2]), .expiry_pulse_n(o[1]),
        .select_out_n(o[0]));
    srw_cpu cpu_u (.clk_sys(clk_sys), .kick_en(kick_en), .kick_one(kick_one),
        .sel_req(sel_req), .kick_in(kick_in), .select_in_n(select_in_n));
    always #50 clk_sys = !clk_sys;
    task wrap_up;
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task put(input srw_pkg::srw_cmp_s c);
        @(negedge clk_sys);
        cmp_in = c;
    endtask
    // Bounded wait for output bit i to reach v
    task wt(input int i, input logic v, input int n, output int w);
        for (w = 0; w < n && o[i] !== v; w++) @(negedge clk_sys);
        if (o[i] !== v) begin
            errors++;
            $display("unexpected at %0t: wait ran out", $time);
            wrap_up();
        end
    endtask
    task t_boot;
        chk(o[6:5], 2'h1);
        chk(o[2:1], 2'h3);
        wt(6, 1'h1, HO + 20, k);
        chk(k >= HO && k <= HO + 5, 1'h1);
    endtask
    task t_trip(input srw_pkg::srw_cmp_s c, input logic hit, input int hold);
        put(c);
        cyc(hold);
        chk(o[6], !hit);
        chk(o[5], hit);
        put(7'h00);
        if (hit) begin
            wt(6, 1'h1, HO + 20, k);
            chk(k >= HO && k <= HO + 6, 1'h1);
        end
    endtask
    task t_lvl(input srw_pkg::srw_cmp_s c, input logic ew, input logic ov);
        put(c);
        cyc(5);
        chk(o[4], ew);
        chk(o[3], ov);
        chk(o[6], 1'h1);
        put(7'h00);
        cyc(5);
    endtask
    task kick;
        @(negedge clk_sys);
        kick_one = 1'h1;
        @(negedge clk_sys);
        kick_one = 1'h0;
    endtask
    task t_wdog;
        kick_en = 1'h0;
        kick();
        wt(1, 1'h0, WD + 20, k);
        chk(k >= WD && k <= WD + 5, 1'h1);
        chk(o[2], 1'h1);
        cyc(1);
        chk(o[2], 1'h0);
        wt(1, 1'h1, PW + 5, k);
        chk(k, PW - 1);
        cyc(WD + 20);
        chk(o[2:1], 2'h1);
        kick();
        wt(2, 1'h1, 8, k);
        chk(k <= 5, 1'h1);
        chk(o[1], 1'h1);
        kick_en = 1'h1;
    endtask
    // Zero capacitance clamps the period to one cycle
    task t_cap;
        kick_en = 1'h0;
        wd_cfg = 18'h20000;
        wt(1, 1'h0, 8, k);
        chk(k <= 3, 1'h1);
        wt(1, 1'h1, PW + 5, k);
        wd_cfg = 18'h10000;
        kick();
        wt(2, 1'h1, 8, k);
        chk(o[2:1], 2'h3);
        kick_en = 1'h1;
    endtask
    task t_sel;
        sel_req = 1'h1;
        cyc(5);
        chk(o[0], 1'h0);
        put(7'h40);
        wt(0, 1'h1, SH + 20, k);
        chk(k >= SH && k <= SH + 6, 1'h1);
        put(7'h00);
        cyc(20);
        chk(o[6:5], 2'h1);
        chk(o[0], 1'h1);
        wt(6, 1'h1, HO + 20, k);
        cyc(5);
        chk(o[0], 1'h0);
        // Select rising early ends the grace window
        put(7'h40);
        cyc(4);
        sel_req = 1'h0;
        wt(0, 1'h1, 6, k);
        chk(k < 5, 1'h1);
        put(7'h00);
        wt(6, 1'h1, HO + 20, k);
    endtask
    initial begin
        cyc(2);
        rst = 1'h0;
        t_boot();
        t_trip(7'h40, 1'h1, 10);
        t_trip(7'h30, 1'h1, 10);
        t_trip(7'h20, 1'h0, 10);
        t_trip(7'h50, 1'h0, 10);
        t_trip(7'h01, 1'h1, 80);
        t_lvl(7'h08, 1'h0, 1'h1);
        t_lvl(7'h14, 1'h0, 1'h1);
        t_lvl(7'h04, 1'h1, 1'h1);
        t_lvl(7'h18, 1'h1, 1'h1);
        t_lvl(7'h02, 1'h1, 1'h0);
        t_wdog();
        t_cap();
        t_sel();
        wrap_up();
    end
endmodule
